//--- sravg_pkg.sv
// shared constants, register map and carrier types for the sample rate / average / offset block
package sravg_pkg;

    // widths
    localparam int ADDR_W     = 9;        // avalon byte address width
    localparam int DATA_W     = 32;       // avalon data width
    localparam int WORD_W     = 16;       // register and sample word width
    localparam int SUM_W      = 32;       // accumulated sum width
    localparam int AVG_W      = 3;        // averaging code width
    localparam int CNT_W      = 18;       // divider counter width (word times four)
    localparam int GRP_W      = 9;        // group size width, up to 128
    localparam int IDX_W      = 7;        // register index width
    localparam int ADDR_LSB   = 2;        // byte address is index times four

    // register indices (byte address = index * 4)
    localparam logic [IDX_W-1:0] IDX_SAMPLE_RATE = 7'h12;
    localparam logic [IDX_W-1:0] IDX_AVG_CFG     = 7'h15;
    localparam logic [IDX_W-1:0] IDX_OFFSET_A1   = 7'h18;
    localparam logic [IDX_W-1:0] IDX_TRIG_SRC    = 7'h4F;
    localparam logic [IDX_W-1:0] IDX_DATA_BUF    = 7'h60;
    localparam logic [IDX_W-1:0] IDX_A1_AVG      = 7'h64;
    localparam logic [IDX_W-1:0] IDX_B1_AVG      = 7'h68;
    localparam logic [IDX_W-1:0] IDX_A1_LOW      = 7'h70;
    localparam logic [IDX_W-1:0] IDX_A1_HIGH     = 7'h74;
    localparam logic [IDX_W-1:0] IDX_B1_LOW      = 7'h78;
    localparam logic [IDX_W-1:0] IDX_B1_HIGH     = 7'h7C;

    // field positions
    localparam int AVG_A_LSB    = 4;      // first slot averaging code [6:4]
    localparam int AVG_B_LSB    = 8;      // second slot averaging code [10:8]
    localparam int TRIG_SEL_LSB = 2;      // trigger source select [3:2]

    // reset values
    localparam logic [WORD_W-1:0] RATE_RESET   = 16'h0028;
    localparam logic [AVG_W-1:0]  AVG_A_RESET  = 3'h0;
    localparam logic [AVG_W-1:0]  AVG_B_RESET  = 3'h6;
    localparam logic [WORD_W-1:0] OFFSET_RESET = 16'h2000;

    // timing: the timebase tick runs at 32 kHz, each divider unit is four ticks
    localparam int TIMEBASE_HZ     = 32000;
    localparam int TICKS_PER_UNIT  = 4;

    // trigger source codes
    typedef enum logic [1:0] {
        TRIG_INTERNAL,
        TRIG_GPIO0,
        TRIG_GPIO1,
        TRIG_RESERVED
    } trig_src_t;

    // avalon-mm request bundle
    typedef struct packed {
        logic                read;
        logic                write;
        logic [ADDR_W-1:0]   address;
        logic [DATA_W-1:0]   writedata;
        logic [DATA_W/8-1:0] byteenable;
    } avmm_req_t;

    // one raw conversion from the adc
    typedef struct packed {
        logic              valid;
        logic              slot_b;      // 0 first slot, 1 second slot
        logic [WORD_W-1:0] data;
    } adc_sample_t;

    // one decimated result from an accumulator
    typedef struct packed {
        logic              valid;
        logic [SUM_W-1:0]  sum;
        logic [WORD_W-1:0] avg;
    } acc_result_t;

    // divider state
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             pulse;
    } div_state_t;

    // accumulator state
    typedef struct packed {
        logic [GRP_W-2:0] count;
        logic [SUM_W-1:0] sum;
        acc_result_t      res;
    } acc_state_t;

    // top-level state
    typedef struct packed {
        logic [WORD_W-1:0] rate_div;
        logic [AVG_W-1:0]  avg_a;
        logic [AVG_W-1:0]  avg_b;
        logic [WORD_W-1:0] offset_a1;
        logic [1:0]        trig_sel;
        logic              gp0_q;
        logic              gp1_q;
        logic              trigger;
        logic              waitreq;
        logic [DATA_W-1:0] rdata;
        logic              a_valid;
        logic              b_valid;
        logic [WORD_W-1:0] a_data;
        logic [WORD_W-1:0] b_data;
        logic [WORD_W-1:0] avg_a1;
        logic [WORD_W-1:0] avg_b1;
        logic [SUM_W-1:0]  sum_a1;
        logic [SUM_W-1:0]  sum_b1;
        logic [WORD_W-1:0] buf_word;
    } top_state_t;

endpackage : sravg_pkg

//--- sample_rate_divider_core.sv
// sample-rate divider: one pulse every divider*4 timebase ticks
`timescale 1ns/1ps
module sample_rate_divider_core (
    input  wire logic                          sys_clk_in,
    input  wire logic                          rst_n_in,
    input  wire logic                          tick_in,     // 32 kHz timebase pulse
    input  wire logic [sravg_pkg::WORD_W-1:0]  divider_in,  // divider register value
    output logic                               pulse_out    // one-cycle sample pulse
);
    sravg_pkg::div_state_t s_reg;
    sravg_pkg::div_state_t s_next;
    logic [sravg_pkg::CNT_W-1:0] target;     // ticks per sample period

    // period in ticks is the register times four
    always_comb begin
        target = sravg_pkg::CNT_W'(divider_in) * sravg_pkg::CNT_W'(sravg_pkg::TICKS_PER_UNIT);
        s_next = s_reg;
        s_next.pulse = 1'b0;
        if (divider_in == '0) begin
            // zero would mean an infinite rate; park the counter instead
            s_next.cnt = '0;
        end else if (tick_in) begin
            if (s_reg.cnt >= target - sravg_pkg::CNT_W'(1)) begin
                s_next.cnt   = '0;
                s_next.pulse = 1'b1;
            end else begin
                s_next.cnt = s_reg.cnt + sravg_pkg::CNT_W'(1);
            end
        end
    end

    // state register
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign pulse_out = s_reg.pulse;
endmodule : sample_rate_divider_core

//--- slot_accumulator.sv
// per-slot sum of 2^n samples with one decimated result per group
`timescale 1ns/1ps
module slot_accumulator (
    input  wire logic                          sys_clk_in,
    input  wire logic                          rst_n_in,
    input  wire logic                          sample_valid_in, // one-cycle sample strobe
    input  wire logic [sravg_pkg::WORD_W-1:0]  sample_in,       // sample, offset-corrected on the first slot only
    input  wire logic [sravg_pkg::AVG_W-1:0]   avg_code_in,     // code n selects 2^n samples
    output sravg_pkg::acc_result_t             result_out       // registered result
);
    sravg_pkg::acc_state_t       s_reg;
    sravg_pkg::acc_state_t       s_next;
    logic [sravg_pkg::SUM_W-1:0] sum_new;    // sum including this sample
    logic [sravg_pkg::GRP_W-1:0] group;      // samples per group

    // accumulate; lowering the code to a group no larger than the samples taken closes the group on the next sample (>=)
    always_comb begin
        group   = sravg_pkg::GRP_W'(1) << avg_code_in;
        sum_new = s_reg.sum + sravg_pkg::SUM_W'(sample_in);
        s_next  = s_reg;
        s_next.res.valid = 1'b0;
        if (sample_valid_in) begin
            if ({1'b0, s_reg.count} + sravg_pkg::GRP_W'(1) >= group) begin
                s_next.res.valid = 1'b1;
                s_next.res.sum   = sum_new;
                s_next.res.avg   = sravg_pkg::WORD_W'(sum_new >> avg_code_in);
                s_next.count     = '0;
                s_next.sum       = '0;
            end else begin
                s_next.count = s_reg.count + 1'b1;
                s_next.sum   = sum_new;
            end
        end
    end

    // state register
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign result_out = s_reg.res;
endmodule : slot_accumulator

//--- sample_rate_average_offset.sv
// sample timing, offset subtraction and per-slot averaging with avalon-mm registers
//
// Contract
// - sample rate is 32 kHz over four times divider
// - second slot averages 2^n samples, reset code 6
// - sum registers hold the last completed group's sum, not average
// - averages go to 16-bit result and buffer
// - each slot outputs once per averaging group
// - first slot has own code, reset code 0
// - subtract programmable offset from first slot channel
// - trigger select: internal divider or gpio pins
`timescale 1ns/1ps
module sample_rate_average_offset (
    input  wire logic                          sys_clk_in,      // 50 MHz system clock
    input  wire logic                          rst_n_in,        // async reset, active low
    input  wire logic                          tick32k_in,      // 32 kHz timebase pulse
    input  wire logic                          gpio0_in,        // external trigger pin 0
    input  wire logic                          gpio1_in,        // external trigger pin 1
    input  sravg_pkg::adc_sample_t             adc_in,          // raw adc conversions
    input  sravg_pkg::avmm_req_t               avmm_req_in,     // avalon-mm request
    output logic [sravg_pkg::DATA_W-1:0]       avmm_readdata_out,
    output logic                               avmm_waitrequest_out,
    output logic                               sample_trigger_out, // one pulse per sample
    output logic                               result_a_valid_out, // first slot result pulse
    output logic                               result_b_valid_out, // second slot result pulse
    output logic [sravg_pkg::WORD_W-1:0]       buffer_word_out     // latest average word
);
    sravg_pkg::top_state_t       s_reg;        // top-level state; divider and accumulators keep their own
    sravg_pkg::top_state_t       s_next;       // next value of the state
    sravg_pkg::acc_result_t      res_a;        // first slot decimated result
    sravg_pkg::acc_result_t      res_b;        // second slot decimated result
    logic                        div_pulse;    // internal sample timing pulse
    logic [sravg_pkg::IDX_W-1:0] idx;          // word index of the access
    logic                        req;          // any request pending
    logic                        accept;       // request completes at this edge
    logic                        gp0_rise;     // rising edge on gpio0
    logic                        gp1_rise;     // rising edge on gpio1
    logic [sravg_pkg::WORD_W:0]  diff_a;       // first slot raw minus offset, with borrow
    logic [sravg_pkg::DATA_W-1:0] rd_mux;      // read data selected by address
    logic [sravg_pkg::DATA_W-1:0] wmask;       // write mask from byte enables

    // internal sample timing from the timebase
    sample_rate_divider_core u_divider (
        .sys_clk_in (sys_clk_in),
        .rst_n_in   (rst_n_in),
        .tick_in    (tick32k_in),
        .divider_in (s_reg.rate_div),
        .pulse_out  (div_pulse)
    );

    // first slot accumulator
    slot_accumulator u_acc_a (
        .sys_clk_in      (sys_clk_in),
        .rst_n_in        (rst_n_in),
        .sample_valid_in (s_reg.a_valid),
        .sample_in       (s_reg.a_data),
        .avg_code_in     (s_reg.avg_a),
        .result_out      (res_a)
    );

    // second slot accumulator
    slot_accumulator u_acc_b (
        .sys_clk_in      (sys_clk_in),
        .rst_n_in        (rst_n_in),
        .sample_valid_in (s_reg.b_valid),
        .sample_in       (s_reg.b_data),
        .avg_code_in     (s_reg.avg_b),
        .result_out      (res_b)
    );

    // request decode; one wait cycle gives registered read data
    always_comb begin
        idx    = avmm_req_in.address[sravg_pkg::ADDR_W-1:sravg_pkg::ADDR_LSB];
        req    = avmm_req_in.read | avmm_req_in.write;
        accept = req & ~s_reg.waitreq;
        for (int i = 0; i < sravg_pkg::DATA_W/8; i++) begin
            wmask[i*8 +: 8] = {8{avmm_req_in.byteenable[i]}};
        end
    end

    // read multiplexer; unmapped words read as zero
    always_comb begin
        rd_mux = '0;
        case (idx)
            sravg_pkg::IDX_SAMPLE_RATE: rd_mux[15:0] = s_reg.rate_div;
            sravg_pkg::IDX_AVG_CFG: begin
                rd_mux[sravg_pkg::AVG_A_LSB +: sravg_pkg::AVG_W] = s_reg.avg_a;
                rd_mux[sravg_pkg::AVG_B_LSB +: sravg_pkg::AVG_W] = s_reg.avg_b;
            end
            sravg_pkg::IDX_OFFSET_A1: rd_mux[15:0] = s_reg.offset_a1;
            sravg_pkg::IDX_TRIG_SRC:  rd_mux[sravg_pkg::TRIG_SEL_LSB +: 2] = s_reg.trig_sel;
            sravg_pkg::IDX_DATA_BUF:  rd_mux[15:0] = s_reg.buf_word;
            sravg_pkg::IDX_A1_AVG:    rd_mux[15:0] = s_reg.avg_a1;
            sravg_pkg::IDX_B1_AVG:    rd_mux[15:0] = s_reg.avg_b1;
            sravg_pkg::IDX_A1_LOW:    rd_mux[15:0] = s_reg.sum_a1[15:0];
            sravg_pkg::IDX_A1_HIGH:   rd_mux[15:0] = s_reg.sum_a1[31:16];
            sravg_pkg::IDX_B1_LOW:    rd_mux[15:0] = s_reg.sum_b1[15:0];
            sravg_pkg::IDX_B1_HIGH:   rd_mux[15:0] = s_reg.sum_b1[31:16];
            default:                  rd_mux = '0;
        endcase
    end

    // next-state logic for the whole block
    always_comb begin
        s_next = s_reg;

        // gpio edge detect; pins are synchronous to the system clock
        s_next.gp0_q = gpio0_in;
        s_next.gp1_q = gpio1_in;
        gp0_rise     = gpio0_in & ~s_reg.gp0_q;
        gp1_rise     = gpio1_in & ~s_reg.gp1_q;

        // sample trigger source; the reserved code gives no triggers
        case (sravg_pkg::trig_src_t'(s_reg.trig_sel))
            sravg_pkg::TRIG_INTERNAL: s_next.trigger = div_pulse;
            sravg_pkg::TRIG_GPIO0:    s_next.trigger = gp0_rise;
            sravg_pkg::TRIG_GPIO1:    s_next.trigger = gp1_rise;
            default:                  s_next.trigger = 1'b0;
        endcase

        // offset subtraction; a negative difference clamps to zero
        diff_a = {1'b0, adc_in.data} - {1'b0, s_reg.offset_a1};
        s_next.a_valid = adc_in.valid & ~adc_in.slot_b;
        s_next.b_valid = adc_in.valid & adc_in.slot_b;
        if (adc_in.valid && !adc_in.slot_b) begin
            s_next.a_data = diff_a[sravg_pkg::WORD_W] ? '0 : diff_a[sravg_pkg::WORD_W-1:0];
        end
        if (adc_in.valid && adc_in.slot_b) begin
            s_next.b_data = adc_in.data;
        end

        // decimated results land in the result, sum and buffer words
        if (res_a.valid) begin
            s_next.avg_a1   = res_a.avg;
            s_next.sum_a1   = res_a.sum;
            s_next.buf_word = res_a.avg;
        end
        if (res_b.valid) begin
            s_next.avg_b1   = res_b.avg;
            s_next.sum_b1   = res_b.sum;
            // second slot follows first in time, so it wins a tie
            s_next.buf_word = res_b.avg;
        end

        // bus handshake: low for exactly one cycle per request
        s_next.waitreq = ~(req & s_reg.waitreq);
        if (req && s_reg.waitreq) begin
            s_next.rdata = avmm_req_in.read ? rd_mux : '0;
        end

        // register writes take effect on the accepting edge only
        if (accept && avmm_req_in.write) begin
            case (idx)
                sravg_pkg::IDX_SAMPLE_RATE: begin
                    s_next.rate_div = (s_reg.rate_div & ~wmask[15:0])
                                    | (avmm_req_in.writedata[15:0] & wmask[15:0]);
                end
                sravg_pkg::IDX_AVG_CFG: begin
                    if (avmm_req_in.byteenable[0]) begin
                        s_next.avg_a = avmm_req_in.writedata[sravg_pkg::AVG_A_LSB +: 3];
                    end
                    if (avmm_req_in.byteenable[1]) begin
                        s_next.avg_b = avmm_req_in.writedata[sravg_pkg::AVG_B_LSB +: 3];
                    end
                end
                sravg_pkg::IDX_OFFSET_A1: begin
                    s_next.offset_a1 = (s_reg.offset_a1 & ~wmask[15:0])
                                     | (avmm_req_in.writedata[15:0] & wmask[15:0]);
                end
                sravg_pkg::IDX_TRIG_SRC: begin
                    if (avmm_req_in.byteenable[0]) begin
                        s_next.trig_sel =
                            avmm_req_in.writedata[sravg_pkg::TRIG_SEL_LSB +: 2];
                    end
                end
                default: begin
                    // read-only or unmapped: write is dropped
                end
            endcase
        end
    end

    // state register with documented reset values
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_reg           <= '0;
            s_reg.rate_div  <= sravg_pkg::RATE_RESET;
            s_reg.avg_a     <= sravg_pkg::AVG_A_RESET;
            s_reg.avg_b     <= sravg_pkg::AVG_B_RESET;
            s_reg.offset_a1 <= sravg_pkg::OFFSET_RESET;
            s_reg.waitreq   <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // outputs straight from flip-flops
    assign avmm_readdata_out    = s_reg.rdata;
    assign avmm_waitrequest_out = s_reg.waitreq;
    assign sample_trigger_out   = s_reg.trigger;
    assign result_a_valid_out   = res_a.valid;
    assign result_b_valid_out   = res_b.valid;
    assign buffer_word_out      = s_reg.buf_word;
endmodule : sample_rate_average_offset

//--- sample_rate_average_offset_sva.sv
// concurrent checks on the ports of the sample rate / average / offset block
`timescale 1ns/1ps
module sample_rate_average_offset_chk (
    input wire logic                          sys_clk_in,
    input wire logic                          rst_n_in,
    input wire logic                          tick32k_in,
    input wire logic                          gpio0_in,
    input wire logic                          gpio1_in,
    input wire sravg_pkg::adc_sample_t        adc_in,
    input wire sravg_pkg::avmm_req_t          avmm_req_in,
    input wire logic [sravg_pkg::DATA_W-1:0]  avmm_readdata_out,
    input wire logic                          avmm_waitrequest_out,
    input wire logic                          sample_trigger_out,
    input wire logic                          result_a_valid_out,
    input wire logic                          result_b_valid_out,
    input wire logic [sravg_pkg::WORD_W-1:0]  buffer_word_out
);
    logic [1:0] sel_q;   // shadow of the trigger source select, seen from bus writes
    logic [2:0] code_a;  // shadow of the first slot averaging code
    wire        req_new = (avmm_req_in.read || avmm_req_in.write) && avmm_waitrequest_out;
    wire        a_smp   = adc_in.valid && !adc_in.slot_b;  // first slot conversion
    wire        b_smp   = adc_in.valid && adc_in.slot_b;   // second slot conversion

    // shadows update on the edge where the write completes, like the registers
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sel_q  <= 2'h0;
            code_a <= 3'h0;
        end else if (avmm_req_in.write && !avmm_waitrequest_out) begin
            if (avmm_req_in.address == 9'h13C) sel_q <= avmm_req_in.writedata[3:2];
            if (avmm_req_in.address == 9'h054) code_a <= avmm_req_in.writedata[6:4];
        end
    end

    default clocking dflt @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);

    // a new request gets exactly one wait cycle, then the bus is idle again
    sequence s_taken; req_new; endsequence
    sequence s_answer; !avmm_waitrequest_out ##1 avmm_waitrequest_out; endsequence
    property p_wait_one; s_taken |=> s_answer; endproperty
    property p_rdata_hold; !req_new |=> $stable(avmm_readdata_out); endproperty
    property p_trig_one; sample_trigger_out |=> !sample_trigger_out; endproperty
    property p_trig_tick; sample_trigger_out && sel_q == 2'h0 |-> $past(tick32k_in, 2); endproperty
    property p_gpio0; sel_q == 2'h1 && $rose(gpio0_in) |-> ##1 sample_trigger_out; endproperty
    property p_none; sel_q == 2'h3 |-> !sample_trigger_out; endproperty
    property p_res_a; result_a_valid_out |-> $past(a_smp, 2); endproperty
    property p_res_a0; code_a == 3'h0 && a_smp |-> ##2 result_a_valid_out; endproperty
    property p_res_b; result_b_valid_out |-> $past(b_smp, 2); endproperty

    a_wait_one: assert property (p_wait_one) else $error("wait cycle not single");
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
    a_trig_one: assert property (p_trig_one) else $error("trigger too long");
    a_trig_tick: assert property (p_trig_tick) else $error("trigger without tick");
    a_gpio0: assert property (p_gpio0) else $error("pin edge lost");
    a_none: assert property (p_none) else $error("trigger while stopped");
    a_res_a: assert property (p_res_a) else $error("first result w/o sample");
    a_res_a0: assert property (p_res_a0) else $error("code 0 not per sample");
    a_res_b: assert property (p_res_b) else $error("second result w/o sample");
endmodule : sample_rate_average_offset_chk

bind sample_rate_average_offset sample_rate_average_offset_chk chk_inst (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .tick32k_in(tick32k_in),
    .gpio0_in(gpio0_in), .gpio1_in(gpio1_in), .adc_in(adc_in), .avmm_req_in(avmm_req_in),
    .avmm_readdata_out(avmm_readdata_out), .avmm_waitrequest_out(avmm_waitrequest_out),
    .sample_trigger_out(sample_trigger_out), .result_a_valid_out(result_a_valid_out),
    .result_b_valid_out(result_b_valid_out), .buffer_word_out(buffer_word_out));

//--- tb_sample_rate_average_offset.sv
// self-checking bench: register bus, trigger sources, averaging and offset path
`timescale 1ns/1ps
module tb_sample_rate_average_offset;
    logic                   sys_clk_in, rst_n_in, tick32k_in, gpio0_in, gpio1_in;
    sravg_pkg::adc_sample_t adc;     // conversions sent to the block
    sravg_pkg::avmm_req_t   req;     // bus request held by the master tasks
    logic [31:0]            rdata;   // block read data
    logic [31:0]            rdq;     // read data taken at the completing edge
    logic                   waitreq, trig, va, vb;
    logic [15:0]            bufw;
    int miscompares, comparisons, cycles, ntrig, na, nb, seed, ph, n, off;
    int rates[4] = '{1, 2, 5, 40};   // ascending so the divider never overshoots

    sample_rate_average_offset sample_rate_average_offset_inst (
        .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .tick32k_in(tick32k_in),
        .gpio0_in(gpio0_in), .gpio1_in(gpio1_in), .adc_in(adc), .avmm_req_in(req),
        .avmm_readdata_out(rdata), .avmm_waitrequest_out(waitreq),
        .sample_trigger_out(trig), .result_a_valid_out(va), .result_b_valid_out(vb),
        .buffer_word_out(bufw));

    // 50 MHz clock
    initial begin
        sys_clk_in = 1'b0;
        forever #10 sys_clk_in = ~sys_clk_in;
    end

    // timebase tick every third cycle, pulse counters and the hang limit
    always @(posedge sys_clk_in) begin
        cycles     <= cycles + 1;
        ph         <= (ph == 2) ? 0 : ph + 1;
        tick32k_in <= (ph == 2);
        if (trig === 1'b1) ntrig <= ntrig + 1;
        if (va === 1'b1) na <= na + 1;
        if (vb === 1'b1) nb <= nb + 1;
        if (cycles == 60000) begin
            miscompares++;
            wrap_up();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one avalon transfer; held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [8:0] a, input logic [31:0] d);
        req.read      <= !wr;
        req.write     <= wr;
        req.address   <= a;
        req.writedata <= d;
        do @(posedge sys_clk_in); while (waitreq !== 1'b0);
        rdq = rdata;
        req.read  <= 1'b0;
        req.write <= 1'b0;
        @(posedge sys_clk_in);
    endtask : bus

    task automatic rd(input logic [8:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rdq, exp);
    endtask : rd

    // cycles until the next trigger pulse, bounded
    task automatic wait_trig(output int c);
        c = 0;
        do begin
            @(posedge sys_clk_in);
            c++;
        end while (trig !== 1'b1 && c < 2000);
    endtask : wait_trig

    // a short high pulse on one trigger pin
    task automatic pulse(input logic pin0);
        if (pin0) gpio0_in <= 1'b1;
        else gpio1_in <= 1'b1;
        repeat (2) @(posedge sys_clk_in);
        gpio0_in <= 1'b0;
        gpio1_in <= 1'b0;
        repeat (2) @(posedge sys_clk_in);
    endtask : pulse

    // one full group of 2^c back-to-back samples, then every result view is checked
    task automatic group(input logic sb, input int c);
        int s, d, a0, b0, avg;
        s  = 0;
        a0 = na;
        b0 = nb;
        for (int i = 0; i < (1 << c); i++) begin
            d = $random(seed) & 16'hFFFF;
            s += sb ? d : ((d > off) ? d - off : 0);  // negative corrected value clamps
            adc <= {1'b1, sb, d[15:0]};
            @(posedge sys_clk_in);
        end
        adc.valid <= 1'b0;
        avg = (s >> c) & 16'hFFFF;
        repeat (4) @(posedge sys_clk_in);
        chk(sb ? nb - b0 : na - a0, 1);
        rd(sb ? 9'h1E0 : 9'h1C0, s & 16'hFFFF);
        rd(sb ? 9'h1F0 : 9'h1D0, s >> 16);
        rd(sb ? 9'h1A0 : 9'h190, avg);
        rd(9'h180, avg);
        chk({16'h0, bufw}, avg);
    endtask : group

    task automatic wrap_up;
        if (miscompares == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : wrap_up

    initial begin
        {rst_n_in, tick32k_in, gpio0_in, gpio1_in} = 4'h0;
        adc = '0;
        req = '0;
        req.byteenable = 4'hF;
        seed = 32'hAABF;
        {miscompares, comparisons, cycles, ntrig, na, nb, ph} = '0;
        repeat (6) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        rd(9'h048, 32'h28);
        bus(1'b1, 9'h048, 32'h1);
        rd(9'h054, 32'h600);
        rd(9'h060, 32'h2000);
        rd(9'h13C, 32'h0);
        rd(9'h004, 32'h0);
        bus(1'b1, 9'h180, 32'hFFFF);
        rd(9'h180, 32'h0);
        // trigger spacing is four ticks per divider unit, three cycles per tick
        foreach (rates[k]) begin
            if (k > 0) bus(1'b1, 9'h048, rates[k]);
            wait_trig(n);
            wait_trig(n);
            chk(n, 12 * rates[k]);
        end
        // pin sources: gpio0 pulsed twice, gpio1 once, reserved code gives none
        for (int s = 1; s < 4; s++) begin
            bus(1'b1, 9'h13C, s << 2);
            rd(9'h13C, s << 2);
            repeat (4) @(posedge sys_clk_in);
            n = ntrig;
            pulse(1'b1);
            pulse(1'b1);
            pulse(1'b0);
            repeat (4) @(posedge sys_clk_in);
            chk(ntrig - n, (s == 1) ? 2 : (s == 2) ? 1 : 0);
        end
        off = $random(seed) & 16'hFFFF;
        bus(1'b1, 9'h060, off);
        rd(9'h060, off);
        // a lane-0-only write must leave the upper byte of the offset alone
        req.byteenable <= 4'h1;
        bus(1'b1, 9'h060, 32'hFFFF);
        req.byteenable <= 4'hF;
        rd(9'h060, {16'h0, off[15:8], 8'hFF});
        bus(1'b1, 9'h060, off);
        // every averaging code on both slots
        for (int c = 0; c < 8; c++) begin
            bus(1'b1, 9'h054, (c << 8) | (c << 4));
            group(1'b0, c);
            group(1'b1, c);
        end
        wrap_up();
    end
endmodule : tb_sample_rate_average_offset
